// [rtl/ebcf_regs.vh]
// Register offsets, reset values and fixed constants of the code fetch bus block
`ifndef EBCF_REGS_VH
`define EBCF_REGS_VH
`define EBCF_IDX_TIMING_LOW   12'h468
`define EBCF_IDX_TIMING_HIGH  12'h469
`define EBCF_IDX_CONFIG       12'h46A
`define EBCF_IDX_CYCLE        12'h46B
`define EBCF_IDX_STATUS       12'h46C
`define EBCF_RST_TIMING_LOW   8'hEF
`define EBCF_RST_TIMING_HIGH  8'hFF
`define EBCF_RST_CONFIG       8'h07
`define EBCF_CFG_WAITEN_BIT   4
`define EBCF_CYC_START_BIT    16
`define EBCF_CYC_CODE_BIT     17
`define EBCF_CYC_WRITE_BIT    18
`define EBCF_ST_BUSY_BIT      0
`define EBCF_ST_SEL_BIT       1
`define EBCF_ST_EXT_BIT       2
`define EBCF_ST_STALL_BIT     3
`define EBCF_INT_LIMIT        16'h7FFF
`define EBCF_ALE_CYCLES       2'd1
`define EBCF_DATA_CYCLES      2'd2
`endif

// [rtl/ebcf_sync.v]
// Two-flop synchroniser for the stall request
`timescale 1ns/1ps
module ebcf_sync
(
    // Clock and reset
    input  wire hclk,
    input  wire hresetn,
    // Level in and out
    input  wire d,
    output wire q
);
    reg s1_q;
    reg s2_q;
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end
        else
        begin
            s1_q <= d;
            s2_q <= s1_q;
        end
    end
    assign q = s2_q;
endmodule // ebcf_sync

// [rtl/ebcf_top.v]
// External bus and code fetch controller with AHB-Lite register port
// How it works
// - Program store strobe goes low during every external code read.
// - Strobe stays high for data accesses, internal fetches and idle.
// - Code source select pin is captured at reset release and held.
// - Captured 0 sends every fetch to external memory.
// - Captured 1 fetches internally up to the limit, externally above.
// - After reset release the shared pin acts as stall request.
// - Stall high during an external cycle stretches it until low.
// - Address latch strobe pulses high only in external address phases.
`timescale 1ns/1ps
`include "ebcf_regs.vh"
module ebcf_top
(
    // AHB-Lite clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    // Shared select / stall pin
    input  wire        code_source_select,
    // External bus
    output reg         program_store_strobe_n,
    output reg         address_latch_strobe,
    output reg         read_strobe_n,
    output reg         write_strobe_n,
    output reg  [15:0] ext_addr,
    output reg  [7:0]  ext_dout,
    output reg         ext_doe,
    input  wire [7:0]  ext_din
);
    localparam ST_IDLE  = 2'd0;
    localparam ST_ADDR  = 2'd1;
    localparam ST_DATA  = 2'd2;
    localparam ST_DONE  = 2'd3;

    reg  [7:0]  timing_low_q;
    reg  [7:0]  timing_high_q;
    reg  [7:0]  config_q;
    reg  [15:0] cyc_addr_q;
    reg         cyc_code_q;
    reg         cyc_write_q;
    reg  [7:0]  cyc_wdata_q;
    reg  [7:0]  rd_data_q;
    reg         sel_q;
    reg         sel_taken_q;
    reg  [1:0]  state_q;
    reg  [1:0]  cnt_q;
    reg         dp_act_q;
    reg         dp_wr_q;
    reg  [11:0] dp_idx_q;
    wire        stall_sync;
    wire        stall_en;
    wire        ext_code;
    wire        start;
    wire [11:0] a_idx;

    // Strap capture at the first edge after reset release
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sel_q       <= 1'b0;
            sel_taken_q <= 1'b0;
        end
        else if (!sel_taken_q)
        begin
            sel_q       <= code_source_select;
            sel_taken_q <= 1'b1;
        end
    end

    // Stall path, only meaningful once the strap is taken
    ebcf_sync u_sync
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       (code_source_select),
        .q       (stall_sync)
    );
    assign stall_en = sel_taken_q & config_q[`EBCF_CFG_WAITEN_BIT] & stall_sync;

    // Code fetch routing
    assign ext_code = (~sel_q) | (cyc_addr_q > `EBCF_INT_LIMIT);

    // AHB-Lite address and data phase
    assign a_idx     = haddr[13:2];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_act_q <= 1'b0;
            dp_wr_q  <= 1'b0;
            dp_idx_q <= 12'h000;
        end
        else if (hready)
        begin
            dp_act_q <= hsel & htrans[1];
            dp_wr_q  <= hwrite;
            dp_idx_q <= a_idx;
        end
    end

    assign start = dp_act_q & dp_wr_q & (dp_idx_q == `EBCF_IDX_CYCLE) &
                   hwdata[`EBCF_CYC_START_BIT] & (state_q == ST_IDLE) & sel_taken_q;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            timing_low_q  <= `EBCF_RST_TIMING_LOW;
            timing_high_q <= `EBCF_RST_TIMING_HIGH;
            config_q      <= `EBCF_RST_CONFIG;
            cyc_addr_q    <= 16'h0000;
            cyc_code_q    <= 1'b0;
            cyc_write_q   <= 1'b0;
            cyc_wdata_q   <= 8'h00;
        end
        else if (dp_act_q && dp_wr_q)
        begin
            if (dp_idx_q == `EBCF_IDX_TIMING_LOW)
                timing_low_q <= hwdata[7:0];
            else if (dp_idx_q == `EBCF_IDX_TIMING_HIGH)
                timing_high_q <= hwdata[7:0];
            else if (dp_idx_q == `EBCF_IDX_CONFIG)
                config_q <= hwdata[7:0];
            else if (start)
            begin
                cyc_addr_q  <= hwdata[15:0];
                cyc_code_q  <= hwdata[`EBCF_CYC_CODE_BIT];
                cyc_write_q <= hwdata[`EBCF_CYC_WRITE_BIT] & ~hwdata[`EBCF_CYC_CODE_BIT];
                cyc_wdata_q <= hwdata[31:24];
            end
        end
    end

    // Read mux, combinational from data phase index
    always @*
    begin
        hrdata = 32'h0000_0000;
        if (dp_act_q && !dp_wr_q)
        begin
            if (dp_idx_q == `EBCF_IDX_TIMING_LOW)
                hrdata = {24'h000000, timing_low_q};
            else if (dp_idx_q == `EBCF_IDX_TIMING_HIGH)
                hrdata = {24'h000000, timing_high_q};
            else if (dp_idx_q == `EBCF_IDX_CONFIG)
                hrdata = {24'h000000, config_q};
            else if (dp_idx_q == `EBCF_IDX_CYCLE)
                hrdata = {rd_data_q, 5'h00, cyc_write_q, cyc_code_q, 1'b0, cyc_addr_q};
            else if (dp_idx_q == `EBCF_IDX_STATUS)
                hrdata = {28'h0000000, stall_sync, ext_code, sel_q, (state_q != ST_IDLE)};
        end
    end

    // External cycle sequencer
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q                <= ST_IDLE;
            cnt_q                  <= 2'd0;
            program_store_strobe_n <= 1'b1;
            address_latch_strobe   <= 1'b0;
            read_strobe_n          <= 1'b1;
            write_strobe_n         <= 1'b1;
            ext_addr               <= 16'h0000;
            ext_dout               <= 8'h00;
            ext_doe                <= 1'b0;
            rd_data_q              <= 8'h00;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        state_q <= ST_ADDR;
                        cnt_q   <= `EBCF_ALE_CYCLES;
                    end
                end
                ST_ADDR:
                begin
                    if (cyc_code_q && !ext_code)
                    begin
                        // Internal fetch, no bus activity
                        state_q <= ST_DONE;
                    end
                    else if (cnt_q != 2'd0)
                    begin
                        address_latch_strobe <= 1'b1;
                        ext_addr             <= cyc_addr_q;
                        cnt_q                <= cnt_q - 2'd1;
                    end
                    else
                    begin
                        address_latch_strobe   <= 1'b0;
                        program_store_strobe_n <= ~cyc_code_q;
                        read_strobe_n          <= cyc_code_q | cyc_write_q;
                        write_strobe_n         <= ~cyc_write_q;
                        ext_dout               <= cyc_wdata_q;
                        ext_doe                <= cyc_write_q;
                        cnt_q                  <= `EBCF_DATA_CYCLES;
                        state_q                <= ST_DATA;
                    end
                end
                ST_DATA:
                begin
                    if (cnt_q != 2'd0)
                        cnt_q <= cnt_q - 2'd1;
                    else if (!stall_en)
                    begin
                        // Stretched while stall request is high
                        rd_data_q              <= ext_din;
                        program_store_strobe_n <= 1'b1;
                        read_strobe_n          <= 1'b1;
                        write_strobe_n         <= 1'b1;
                        ext_doe                <= 1'b0;
                        state_q                <= ST_DONE;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // ebcf_top

// [tb/ebcf_ext_mem.sv]
// External memory and stall source model
`timescale 1ns/1ps
module ebcf_ext_mem
(
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // Bench controls
    input  wire        strap,
    input  wire [3:0]  stall_len,
    // Bus pins
    input  wire        program_store_strobe_n,
    input  wire        read_strobe_n,
    input  wire [15:0] ext_addr,
    output wire [7:0]  ext_din,
    output wire        code_source_select
);
    reg  [1:0] hold_q;
    reg  [3:0] cnt_q;
    reg  [7:0] last_q;
    wire       act = !program_store_strobe_n || !read_strobe_n;
    // Strap until taken, then stall while reading
    assign code_source_select = hold_q[1] ? (act && cnt_q < stall_len) : strap;
    // Released bus shows the inverse of the last byte
    assign ext_din = act ? (ext_addr[7:0] ^ 8'hA5) : ~last_q;
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hold_q <= 2'h0;
            cnt_q  <= 4'h0;
            last_q <= 8'h00;
        end
        else
        begin
            hold_q <= {hold_q[0], 1'b1};
            cnt_q  <= act ? cnt_q + {3'h0, cnt_q < stall_len} : 4'h0;
            last_q <= ext_din;
        end
    end
endmodule // ebcf_ext_mem

// [tb/ebcf_top_asserts.sv]
// Strobe timing checker for the external bus block
`timescale 1ns/1ps
module ebcf_chk
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // External strobes
    input wire logic address_latch_strobe,
    input wire logic program_store_strobe_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic quiet = program_store_strobe_n & read_strobe_n & write_strobe_n;
    sequence ale_s;
        address_latch_strobe ##1 !address_latch_strobe;
    endsequence
    ale_one_a: assert property ($rose(address_latch_strobe) |-> ale_s)
        else $error("ALE wider than one cycle");
    ale_strb_a: assert property (ale_s |-> !quiet)
        else $error("No strobe after ALE");
    ale_idle_a: assert property (!quiet |-> !address_latch_strobe)
        else $error("ALE during strobe");
    code_ale_a: assert property ($fell(program_store_strobe_n) |-> $past(address_latch_strobe))
        else $error("Code strobe without ALE");
    code_len_a: assert property ($fell(program_store_strobe_n) |-> !program_store_strobe_n [*3])
        else $error("Code strobe too short");
    code_only_a: assert property (!program_store_strobe_n |-> read_strobe_n && write_strobe_n)
        else $error("Code strobe with data strobe");
    rd_wr_a: assert property (!read_strobe_n |-> write_strobe_n)
        else $error("Read and write strobe together");
    code_end_a: assert property ($rose(program_store_strobe_n) |-> !address_latch_strobe ##1 quiet)
        else $error("Bus not idle after code strobe");
endmodule // ebcf_chk
bind ebcf_top ebcf_chk i_chk (.hclk(hclk), .hresetn(hresetn), .address_latch_strobe(address_latch_strobe),
    .program_store_strobe_n(program_store_strobe_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n));

// [tb/tb_external_bus_code_fetch.sv]
// Self-checking bench for the external bus block
`timescale 1ns/1ps
`include "ebcf_regs.vh"
module tb_external_bus_code_fetch;
    logic        hclk, hresetn, hsel, hwrite, strap;
    logic [31:0] haddr, hwdata, rdq;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  stall_len;
    wire  [31:0] hrdata;
    wire  [15:0] eaddr;
    wire  [7:0]  din;
    wire  [7:0]  dout;
    wire         hrdy, cs, cstb_n, ale, rd_n, wr_n, doe, hresp;
    int          n_mismatch, checks_done, n_low, n_rd, n_ale, n_wr, n_doe, n_err;
    logic [15:0] ale_addr;
    logic [7:0]  wr_byte;
    logic [7:0]  exp_q[$];
    ebcf_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
        .hresp(hresp), .code_source_select(cs), .program_store_strobe_n(cstb_n), .address_latch_strobe(ale),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .ext_addr(eaddr), .ext_dout(dout), .ext_doe(doe),
        .ext_din(din));
    ebcf_ext_mem i_mem (.hclk(hclk), .hresetn(hresetn), .strap(strap), .stall_len(stall_len),
        .program_store_strobe_n(cstb_n), .read_strobe_n(rd_n), .ext_addr(eaddr), .ext_din(din),
        .code_source_select(cs));
    always @(posedge hclk)
    begin
        rdq <= hrdata;
        n_low = n_low + !cstb_n;
        n_rd = n_rd + !rd_n;
        n_ale = n_ale + ale;
        n_wr = n_wr + !wr_n;
        n_doe = n_doe + doe;
        n_err = n_err + hresp;
        if (ale)
            ale_addr = eaddr;
        if (!wr_n)
            wr_byte = dout;
    end
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task ahb(input logic w, input logic [11:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {18'h0, idx, 2'b00};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hrdy !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hrdy !== 1'b1);
        #1 rd = rdq;
    endtask
    task rst(input logic s);
        @(posedge hclk);
        hresetn <= 1'b0;
        strap <= s;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
    endtask
    // Run one cycle, then poll busy with a bound
    task cyc(input logic code, input logic wr, input logic [7:0] wd, input logic [15:0] a);
        logic [31:0] r;
        int i;
        n_low = 0;
        n_rd = 0;
        n_ale = 0;
        n_wr = 0;
        n_doe = 0;
        ale_addr = ~a;
        wr_byte = ~wd;
        // Expected byte of a plain data read, popped when the cycle register is read
        if (!code && !wr)
            exp_q.push_back(a[7:0] ^ 8'hA5);
        ahb(1'b1, `EBCF_IDX_CYCLE, {wd, 5'h00, wr, code, 1'b1, a}, r);
        r = 1;
        for (i = 0; i < 40 && r[0]; i++)
            ahb(1'b0, `EBCF_IDX_STATUS, 32'h0, r);
        chk("busy cleared", 0, {31'h0, r[0]});
        repeat (2) @(posedge hclk);
    endtask
    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    initial
    begin
        repeat (20000) @(posedge hclk);
        n_mismatch++;
        test_done;
    end
    initial
    begin
        logic [31:0] r;
        logic [15:0] a;
        logic [7:0]  b;
        {hresetn, hsel, hwrite, strap, haddr, hwdata, htrans, stall_len} = '0;
        hsize = 3'h2;
        void'($urandom(50363));
        rst(1'b0);
        ahb(1'b0, `EBCF_IDX_TIMING_HIGH, 32'h0, r);
        chk("timing high", 32'h000000FF, r);
        ahb(1'b0, 12'h7F0, 32'h0, r);
        chk("unmapped", 32'h0, r);
        b = $urandom;
        ahb(1'b1, `EBCF_IDX_TIMING_LOW, {24'h0, b}, r);
        ahb(1'b0, `EBCF_IDX_TIMING_LOW, 32'h0, r);
        chk("timing low", {24'h0, b}, r);
        ahb(1'b0, `EBCF_IDX_STATUS, 32'h0, r);
        chk("captured select", 32'h0, {31'h0, r[1]});
        a = $urandom;
        cyc(1'b1, 1'b0, 8'h00, a & 16'h7FFF);
        chk("ale address", {16'h0, a & 16'h7FFF}, {16'h0, ale_addr});
        chk("code strobe cycles", 3, n_low);
        chk("ale pulses", 1, n_ale);
        a = $urandom;
        cyc(1'b0, 1'b0, 8'h00, a);
        chk("code strobe on data", 0, n_low);
        chk("read strobe cycles", 3, n_rd);
        ahb(1'b0, `EBCF_IDX_CYCLE, 32'h0, r);
        chk("read data", {24'h0, exp_q.pop_front()}, {24'h0, r[31:24]});
        b = $urandom;
        cyc(1'b0, 1'b1, b, a);
        chk("code strobe on write", 0, n_low + n_rd);
        chk("write strobe cycles", 3, n_wr);
        chk("write drive cycles", 3, n_doe);
        chk("write data", {24'h0, b}, {24'h0, wr_byte});
        chk("write address", {16'h0, a}, {16'h0, ale_addr});
        stall_len <= 4'h4;
        cyc(1'b1, 1'b0, 8'h00, a);
        chk("stall disabled", 3, n_low);
        ahb(1'b1, `EBCF_IDX_CONFIG, 32'h17, r);
        cyc(1'b1, 1'b0, 8'h00, a);
        chk("stall stretch", 1, n_low > 3);
        stall_len <= 4'h0;
        rst(1'b1);
        ahb(1'b0, `EBCF_IDX_STATUS, 32'h0, r);
        chk("captured select", 32'h1, {31'h0, r[1]});
        cyc(1'b1, 1'b0, 8'h00, 16'h0100);
        chk("internal fetch", 0, n_low + n_ale);
        ahb(1'b0, `EBCF_IDX_STATUS, 32'h0, r);
        chk("code address external", 0, {31'h0, r[2]});
        cyc(1'b1, 1'b0, 8'h00, 16'h8000);
        chk("external above limit", 3, n_low);
        ahb(1'b0, `EBCF_IDX_STATUS, 32'h0, r);
        chk("code address external", 1, {31'h0, r[2]});
        chk("stall idle", 0, {31'h0, r[3]});
        chk("error responses", 0, n_err);
        test_done;
    end
endmodule // tb_external_bus_code_fetch
